// [design/thaoir_bank.sv]
// high alert threshold, offset calibration and pin snapshot register bank
//
// How it works
// - corrected result above high limit sets the high-alert status flag
// - alarm search answer carries the alert bit while the condition holds
// - alert condition with supply-pin power and pin 2 in alert mode drives the alert pin low
// - limit low byte at offset 0ah, resets to f0h
// - limit high byte at offset 0bh, resets to 07h
// - factory and first power-up values are in the legacy format
// - copy command saves limit and offset bytes into configuration eeprom
// - power-on reset reloads limit and offset from configuration eeprom
// - offset is added to every raw result before it is stored
// - the corrected result, not the raw one, meets the limit
// - offset low byte at offset 0ch, resets to 00h
// - offset high byte at offset 0dh, resets to zero
// - pin snapshot captures the four pins only on a pin-read command
// - snapshot bits 3..0 hold true pin levels, reset to zero
// - snapshot bits 7..4 hold inverted levels, reset to one
// - pin 2 in alert mode reports the alert pin status
// - protection bit blocks writes to limit and offset; writes cannot clear it
`timescale 1ns/1ps
`include "thaoir_consts.svh"
module thaoir_bank (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic factory_rst,
   input wire thaoir_pkg::thaoir_sp_req_s sp_req,
   input wire logic copy_cmd,
   input wire logic pin_read_cmd,
   input wire logic alarm_search_cmd,
   input wire thaoir_pkg::thaoir_conv_s conv,
   input wire logic lock_en,
   input wire logic io2_alert_mode,
   input wire logic vdd_pwr_in,
   input wire logic [3:0] io_pin_in,
   output logic [7:0] sp_rdata_r,
   output logic [15:0] result_r,
   output logic result_vld_r,
   output logic alert_high_r,
   output logic alarm_resp_r,
   output logic alarm_resp_vld_r,
   output logic alert_pin_out_r,
   output logic alert_pin_oe_r,
   output logic [7:0] pin_snapshot_r,
   output logic busy_r
);
   import thaoir_pkg::*;

   localparam int NB = `THAOIR_NUM_BYTES;
   localparam logic [8*NB-1:0] RST_VEC = {`THAOIR_RST_CAL_HI, `THAOIR_RST_CAL_LO,
                                          `THAOIR_RST_LIM_HI, `THAOIR_RST_LIM_LO};
   localparam logic [8*NB-1:0] OFS_VEC = {`THAOIR_OFS_CAL_HI, `THAOIR_OFS_CAL_LO,
                                          `THAOIR_OFS_LIM_HI, `THAOIR_OFS_LIM_LO};

   thaoir_state_e state_r;
   logic [1:0] cnt_r;
   logic ld_vld_r;
   logic [1:0] ld_idx_r;
   logic [7:0] cfg_r [NB];
   logic [7:0] nvm_rdata;
   logic [7:0] save_byte;
   logic nvm_we;
   logic [3:0] pin_s1_r;
   logic [3:0] pin_s2_r;
   logic vdd_s1_r;
   logic vdd_s2_r;
   logic [15:0] limit;
   logic [15:0] offset;
   logic [15:0] corrected;
   logic alert_cond_r;
   logic [3:0] pin_view;
   logic host_wr_ok;
   logic copy_take;
   logic alert_cmp;
   logic busy_nxt;
   logic [NB-1:0] wr_hit;
   logic [7:0] snap_nxt;

   ////////////////////////////////////////////////////////////////
   // pin and power-mode synchronisers

   // two flops before any logic looks at the pins
   always_ff @(posedge ref_clk)
   begin
      pin_s1_r <= io_pin_in;
      pin_s2_r <= pin_s1_r;
   end

   // supply-pin power detect, same treatment
   always_ff @(posedge ref_clk)
   begin
      vdd_s1_r <= vdd_pwr_in;
      vdd_s2_r <= vdd_s1_r;
   end

   ////////////////////////////////////////////////////////////////
   // reload and save sequencer

   // a copy is taken only while idle with no reload byte in flight
   assign copy_take = copy_cmd && (state_r == ST_IDLE) && !ld_vld_r;

   // rst starts a reload; copy only accepted when idle
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_r <= ST_LOAD;
         cnt_r <= `THAOIR_IDX_LIM_LO;
      end
      else
      begin
         unique case (state_r)
            ST_LOAD:
            begin
               cnt_r <= cnt_r + 2'h1;
               if (cnt_r == `THAOIR_IDX_LAST)
                  state_r <= ST_IDLE;
            end
            ST_IDLE:
            begin
               cnt_r <= `THAOIR_IDX_LIM_LO;
               if (copy_take)
                  state_r <= ST_SAVE;
            end
            ST_SAVE:
            begin
               cnt_r <= cnt_r + 2'h1;
               if (cnt_r == `THAOIR_IDX_LAST)
                  state_r <= ST_IDLE;
            end
            default:
            begin
               state_r <= ST_LOAD; // stray code: start over with a reload
               cnt_r <= `THAOIR_IDX_LIM_LO;
            end
         endcase
      end
   end

   // eeprom read data arrives one cycle after its address
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ld_vld_r <= 1'b0;
         ld_idx_r <= `THAOIR_IDX_LIM_LO;
      end
      else
      begin
         ld_vld_r <= (state_r == ST_LOAD);
         ld_idx_r <= cnt_r;
      end
   end

   // busy away from idle and while the last reload byte lands
   always_comb
   begin
      busy_nxt = 1'b0;
      if (state_r != ST_IDLE)
         busy_nxt = 1'b1;
      if (ld_vld_r)
         busy_nxt = 1'b1;
   end

   // busy while reloading or saving; host writes meanwhile are dropped
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         busy_r <= 1'b1;
      else
         busy_r <= busy_nxt;
   end

   // eeprom write port is fed byte by byte while saving
   assign nvm_we = (state_r == ST_SAVE);
   assign save_byte = cfg_r[cnt_r];

   // factory image holds the legacy-format reset values
   thaoir_nvm #(
      .DEPTH(NB),
      .AW(2),
      .FACTORY(RST_VEC)
   ) u_nvm (
      .ref_clk(ref_clk),
      .factory_rst(factory_rst),
      .we(nvm_we),
      .waddr(cnt_r),
      .wdata(save_byte),
      .raddr(cnt_r),
      .rdata_r(nvm_rdata)
   );

   ////////////////////////////////////////////////////////////////
   // limit and offset bytes

   // host writes pass only when idle and not protected
   assign host_wr_ok = sp_req.wr && !lock_en && (state_r == ST_IDLE) && !ld_vld_r;

   // one register per byte; reload beats a host write
   for (genvar i = 0; i < NB; i++)
   begin : g_cfg
      // this byte is the target of an accepted host write
      assign wr_hit[i] = host_wr_ok && (sp_req.addr == OFS_VEC[8*i +: 8]);

      always_ff @(posedge ref_clk)
      begin
         if (rst)
            cfg_r[i] <= RST_VEC[8*i +: 8];
         else if (ld_vld_r && (ld_idx_r == 2'(i)))
            cfg_r[i] <= nvm_rdata;
         else if (wr_hit[i])
            cfg_r[i] <= sp_req.wdata;
      end
   end

   // sixteen-bit values, high byte above low byte
   assign limit = {cfg_r[`THAOIR_IDX_LIM_HI], cfg_r[`THAOIR_IDX_LIM_LO]};
   assign offset = {cfg_r[`THAOIR_IDX_CAL_HI], cfg_r[`THAOIR_IDX_CAL_LO]};

   ////////////////////////////////////////////////////////////////
   // scratchpad read-back

   // unmapped offsets read as zero
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         sp_rdata_r <= `THAOIR_READ_ZERO;
      else if (sp_req.rd)
      begin
         unique case (sp_req.addr)
            `THAOIR_OFS_LIM_LO: sp_rdata_r <= cfg_r[`THAOIR_IDX_LIM_LO];
            `THAOIR_OFS_LIM_HI: sp_rdata_r <= cfg_r[`THAOIR_IDX_LIM_HI];
            `THAOIR_OFS_CAL_LO: sp_rdata_r <= cfg_r[`THAOIR_IDX_CAL_LO];
            `THAOIR_OFS_CAL_HI: sp_rdata_r <= cfg_r[`THAOIR_IDX_CAL_HI];
            default: sp_rdata_r <= `THAOIR_READ_ZERO;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // result correction and high-limit compare

   // two's complement add, wraps at sixteen bits
   assign corrected = conv.raw + offset;

   // corrected result is stored with a one-cycle valid pulse
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         result_r <= `THAOIR_RST_RESULT;
         result_vld_r <= 1'b0;
      end
      else
      begin
         result_vld_r <= conv.done;
         if (conv.done)
            result_r <= corrected;
      end
   end

   // signed strict compare of the corrected result against the high limit
   assign alert_cmp = ($signed(corrected) > $signed(limit));

   // condition follows the latest result, signed compare
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         alert_cond_r <= 1'b0;
      else if (conv.done)
         alert_cond_r <= alert_cmp;
   end

   // status flag shows the condition of the latest result
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         alert_high_r <= 1'b0;
      else
         alert_high_r <= alert_cond_r;
   end

   ////////////////////////////////////////////////////////////////
   // alarm search answer

   // answer bit sampled on each search, valid for one cycle
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         alarm_resp_r <= 1'b0;
         alarm_resp_vld_r <= 1'b0;
      end
      else
      begin
         alarm_resp_vld_r <= alarm_search_cmd;
         if (alarm_search_cmd)
            alarm_resp_r <= alert_cond_r;
      end
   end

   ////////////////////////////////////////////////////////////////
   // alert pin drive

   // open drain: level is always low, enable pulls the pin
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         alert_pin_out_r <= 1'b0;
      else
         alert_pin_out_r <= 1'b0;
   end

   // pulled low only with supply-pin power and pin 2 in alert mode
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         alert_pin_oe_r <= 1'b0;
      else
         alert_pin_oe_r <= alert_cond_r && vdd_s2_r && io2_alert_mode;
   end

   ////////////////////////////////////////////////////////////////
   // pin snapshot

   // pin 2 reports the alert pin status when it serves as alert
   always_comb
   begin
      pin_view = pin_s2_r;
      if (io2_alert_mode)
         pin_view[`THAOIR_PIN_ALERT] = !alert_pin_oe_r;
   end

   // snapshot image: inverted levels above true levels
   assign snap_nxt = {~pin_view, pin_view};

   // captured only on a pin-read command
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         pin_snapshot_r <= `THAOIR_RST_SNAP;
      else if (pin_read_cmd)
         pin_snapshot_r <= snap_nxt;
   end

endmodule : thaoir_bank

// [design/thaoir_consts.svh]
// named offsets, reset values and indices of the alert and offset register bank
`ifndef THAOIR_CONSTS_SVH
`define THAOIR_CONSTS_SVH

// scratchpad offsets of the four settable bytes
`define THAOIR_OFS_LIM_LO 8'h0a
`define THAOIR_OFS_LIM_HI 8'h0b
`define THAOIR_OFS_CAL_LO 8'h0c
`define THAOIR_OFS_CAL_HI 8'h0d

// reset and factory values
`define THAOIR_RST_LIM_LO 8'hf0
`define THAOIR_RST_LIM_HI 8'h07
`define THAOIR_RST_CAL_LO 8'h00
`define THAOIR_RST_CAL_HI 8'h00
`define THAOIR_RST_SNAP 8'hf0
`define THAOIR_READ_ZERO 8'h00
`define THAOIR_RST_RESULT 16'h0000

// byte index inside the bank and inside the configuration eeprom
`define THAOIR_IDX_LIM_LO 2'h0
`define THAOIR_IDX_LIM_HI 2'h1
`define THAOIR_IDX_CAL_LO 2'h2
`define THAOIR_IDX_CAL_HI 2'h3
`define THAOIR_IDX_LAST 2'h3
`define THAOIR_NUM_BYTES 4

// pin that doubles as the alert output
`define THAOIR_PIN_ALERT 2

`endif

// [design/thaoir_pkg.sv]
// types shared by the alert and offset register bank
package thaoir_pkg;

   // sequencer states: eeprom reload, idle, eeprom save
   typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_SAVE} thaoir_state_e;

   // scratchpad access from the bus protocol engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } thaoir_sp_req_s;

   // raw conversion result from the conversion engine
   typedef struct packed {
      logic done;
      logic [15:0] raw;
   } thaoir_conv_s;

endpackage : thaoir_pkg

// [design/thaoir_nvm.sv]
// configuration eeprom bytes with registered read data
`timescale 1ns/1ps
module thaoir_nvm #(
   parameter int DEPTH = 4,
   parameter int AW = 2,
   parameter logic [8*DEPTH-1:0] FACTORY = {8'h00, 8'h00, 8'h07, 8'hf0}
) (
   input wire logic ref_clk,
   input wire logic factory_rst,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [7:0] rdata_r
);

   logic [7:0] mem_r [DEPTH];

   ////////////////////////////////////////////////////////////////
   // one storage byte per entry; only the factory strobe restores it
   for (genvar i = 0; i < DEPTH; i++)
   begin : g_byte
      always_ff @(posedge ref_clk)
      begin
         if (factory_rst)
            mem_r[i] <= FACTORY[8*i +: 8];
         else if (we && (waddr == AW'(i)))
            mem_r[i] <= wdata;
      end
   end

   ////////////////////////////////////////////////////////////////
   // registered read port
   always_ff @(posedge ref_clk)
   begin
      rdata_r <= mem_r[raddr];
   end

endmodule : thaoir_nvm

// [testbench/thaoir_monitor.sv]
// concurrent checks on the ports of the alert and offset register bank
`timescale 1ns/1ps
module thaoir_monitor (
   input wire logic ref_clk,
   input wire logic rst,
   input wire thaoir_pkg::thaoir_sp_req_s sp_req,
   input wire thaoir_pkg::thaoir_conv_s conv,
   input wire logic copy_cmd,
   input wire logic pin_read_cmd,
   input wire logic alarm_search_cmd,
   input wire logic [7:0] sp_rdata_r,
   input wire logic [15:0] result_r,
   input wire logic result_vld_r,
   input wire logic alert_high_r,
   input wire logic alarm_resp_r,
   input wire logic alarm_resp_vld_r,
   input wire logic alert_pin_out_r,
   input wire logic alert_pin_oe_r,
   input wire logic [7:0] pin_snapshot_r,
   input wire logic busy_r
);
   import thaoir_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   // one clock domain, all checks off during reset
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   a_vld_after_conv: assert property (conv.done |=> result_vld_r)
      else $error("no result pulse");
   a_result_holds: assert property (!$past(conv.done) && !$past(rst) |-> $stable(result_r))
      else $error("result moved");
   a_alarm_answer: assert property (alarm_search_cmd |=> alarm_resp_vld_r)
      else $error("no alarm answer");
   a_alarm_value: assert property (alarm_resp_vld_r && !$past(conv.done) && !$past(conv.done, 2)
      |-> alarm_resp_r == alert_high_r) else $error("alarm bit wrong");
   a_pin_pull: assert property (alert_pin_oe_r |-> alert_high_r && !alert_pin_out_r)
      else $error("alert pin wrong");
   a_snap_inverse: assert property (pin_snapshot_r[7:4] == ~pin_snapshot_r[3:0])
      else $error("snapshot halves");
   a_snap_holds: assert property (!$past(pin_read_cmd) && !$past(rst)
      |-> $stable(pin_snapshot_r)) else $error("snapshot moved");
   a_flag_follows: assert property (!$past(result_vld_r) && !$past(rst) |-> $stable(alert_high_r))
      else $error("flag moved without result");
   a_copy_busy: assert property (copy_cmd && !busy_r |-> ##[1:3] busy_r)
      else $error("copy ignored");
   a_save_ends: assert property ($rose(busy_r) |-> ##[1:8] !busy_r)
      else $error("save too long");
   a_reload_ends: assert property ($fell(rst) |-> ##[1:8] !busy_r)
      else $error("reload too long");
endmodule : thaoir_monitor

bind thaoir_bank thaoir_monitor i_thaoir_monitor (
   .ref_clk(ref_clk),
   .rst(rst),
   .sp_req(sp_req),
   .conv(conv),
   .copy_cmd(copy_cmd),
   .pin_read_cmd(pin_read_cmd),
   .alarm_search_cmd(alarm_search_cmd),
   .sp_rdata_r(sp_rdata_r),
   .result_r(result_r),
   .result_vld_r(result_vld_r),
   .alert_high_r(alert_high_r),
   .alarm_resp_r(alarm_resp_r),
   .alarm_resp_vld_r(alarm_resp_vld_r),
   .alert_pin_out_r(alert_pin_out_r),
   .alert_pin_oe_r(alert_pin_oe_r),
   .pin_snapshot_r(pin_snapshot_r),
   .busy_r(busy_r)
);

// [testbench/thaoir_host.sv]
// bus host model: scratchpad access and function commands
`timescale 1ns/1ps
module thaoir_host (
   input wire logic ref_clk,
   output thaoir_pkg::thaoir_sp_req_s sp_req,
   output logic copy_cmd,
   output logic pin_read_cmd,
   output logic alarm_search_cmd
);
   import thaoir_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   // idle bus at time zero
   initial
   begin
      sp_req = '0;
      {copy_cmd, pin_read_cmd, alarm_search_cmd} = 3'h0;
   end
   // one-cycle write; released lines show the inverse of the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      sp_req = '{1'b1, 1'b0, a, d};
      @(negedge ref_clk);
      sp_req = '{1'b0, 1'b0, ~a, ~d};
   endtask : wr
   // one-cycle read; data stands after the taking edge
   task automatic rd(input logic [7:0] a);
      @(negedge ref_clk);
      sp_req = '{1'b0, 1'b1, a, 8'h00};
      @(negedge ref_clk);
      sp_req = '{1'b0, 1'b0, ~a, 8'hff};
   endtask : rd
   // function pulse: copy, pin read, alarm search
   task automatic fn(input logic [2:0] k);
      @(negedge ref_clk);
      {copy_cmd, pin_read_cmd, alarm_search_cmd} = k;
      @(negedge ref_clk);
      {copy_cmd, pin_read_cmd, alarm_search_cmd} = 3'h0;
   endtask : fn
endmodule : thaoir_host

// [testbench/tb_thaoir_bank.sv]
// self-checking bench for the alert and offset register bank
`timescale 1ns/1ps
module tb_thaoir_bank;
   import thaoir_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1, factory_rst = 1'b1, lock_en = 1'b0, io2_alert_mode = 1'b0, vdd_pwr_in = 1'b1;
   logic [3:0] io_pin_in = 4'h0;
   thaoir_conv_s conv = '0;
   thaoir_sp_req_s sp_req;
   logic copy_cmd, pin_read_cmd, alarm_search_cmd, result_vld_r, alert_high_r, alarm_resp_r, alarm_resp_vld_r;
   logic alert_pin_out_r, alert_pin_oe_r, busy_r;
   logic [7:0] sp_rdata_r, pin_snapshot_r;
   logic [15:0] result_r;
   logic [7:0] rst_img [4] = '{8'hf0, 8'h07, 8'h00, 8'h00};
   int failures = 0, tests_run = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // 20 mhz clock, host model and design
   always #25 ref_clk = ~ref_clk;
   thaoir_host i_thaoir_host (.ref_clk(ref_clk), .sp_req(sp_req), .copy_cmd(copy_cmd),
      .pin_read_cmd(pin_read_cmd), .alarm_search_cmd(alarm_search_cmd));
   thaoir_bank i_thaoir_bank (
      .ref_clk(ref_clk),
      .rst(rst),
      .factory_rst(factory_rst),
      .sp_req(sp_req),
      .copy_cmd(copy_cmd),
      .pin_read_cmd(pin_read_cmd),
      .alarm_search_cmd(alarm_search_cmd),
      .conv(conv),
      .lock_en(lock_en),
      .io2_alert_mode(io2_alert_mode),
      .vdd_pwr_in(vdd_pwr_in),
      .io_pin_in(io_pin_in),
      .sp_rdata_r(sp_rdata_r),
      .result_r(result_r),
      .result_vld_r(result_vld_r),
      .alert_high_r(alert_high_r),
      .alarm_resp_r(alarm_resp_r),
      .alarm_resp_vld_r(alarm_resp_vld_r),
      .alert_pin_out_r(alert_pin_out_r),
      .alert_pin_oe_r(alert_pin_oe_r),
      .pin_snapshot_r(pin_snapshot_r),
      .busy_r(busy_r)
   );
   ////////////////////////////////////////////////////////////////////////////////
   // compare, verdict and helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize();
      $display("tests_run=%0d failures=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize
   task automatic wait_idle();
      for (int i = 0; i < 20 && busy_r !== 1'b0; i++)
         @(negedge ref_clk);
      if (busy_r !== 1'b0)
      begin
         failures++;
         summarize();
      end
   endtask : wait_idle
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      i_thaoir_host.rd(a);
      chk(sp_rdata_r, exp);
   endtask : rdc
   task automatic cnv(input logic [15:0] raw, input logic [15:0] res, input logic al);
      @(negedge ref_clk);
      conv = '{1'b1, raw};
      @(negedge ref_clk);
      conv = '{1'b0, ~raw};
      repeat (2) @(negedge ref_clk);
      chk(result_r, res);
      chk(alert_high_r, al);
   endtask : cnv
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      repeat (10) @(negedge ref_clk);
      chk(pin_snapshot_r, 8'hf0);
      {rst, factory_rst} = 2'b00;
      wait_idle();
      for (int i = 0; i < 4; i++)
         rdc(8'h0a + i[7:0], rst_img[i]);
      rdc(8'h0e, 8'h00);
      io2_alert_mode = 1'b1;
      cnv(16'h07f0, 16'h07f0, 1'b0);
      cnv(16'h07f1, 16'h07f1, 1'b1);
      chk(alert_pin_oe_r, 1'b1);
      i_thaoir_host.fn(3'b001);
      chk({alarm_resp_vld_r, alarm_resp_r}, 2'b11);
      io_pin_in = 4'hf;
      repeat (3) @(negedge ref_clk);
      i_thaoir_host.fn(3'b010);
      chk(pin_snapshot_r, 8'h4b);
      io_pin_in = 4'h5;
      repeat (3) @(negedge ref_clk);
      chk(pin_snapshot_r, 8'h4b);
      i_thaoir_host.fn(3'b010);
      chk(pin_snapshot_r, 8'he1);
      io2_alert_mode = 1'b0;
      i_thaoir_host.fn(3'b010);
      chk(pin_snapshot_r, 8'ha5);
      chk(alert_pin_oe_r, 1'b0);
      io2_alert_mode = 1'b1;
      vdd_pwr_in = 1'b0;
      repeat (3) @(negedge ref_clk);
      cnv(16'h07f2, 16'h07f2, 1'b1);
      chk(alert_pin_oe_r, 1'b0);
      vdd_pwr_in = 1'b1;
      i_thaoir_host.wr(8'h0c, 8'hf0);
      i_thaoir_host.wr(8'h0d, 8'hff);
      cnv(16'h07f5, 16'h07e5, 1'b0);
      cnv(16'h0000, 16'hfff0, 1'b0);
      lock_en = 1'b1;
      i_thaoir_host.wr(8'h0a, 8'h55);
      rdc(8'h0a, 8'hf0);
      lock_en = 1'b0;
      i_thaoir_host.wr(8'h0a, 8'h12);
      i_thaoir_host.fn(3'b100);
      i_thaoir_host.wr(8'h0a, 8'h99);
      wait_idle();
      rdc(8'h0a, 8'h12);
      i_thaoir_host.wr(8'h0a, 8'h34);
      rdc(8'h0a, 8'h34);
      rst = 1'b1;
      @(negedge ref_clk);
      rst = 1'b0;
      wait_idle();
      rdc(8'h0a, 8'h12);
      rdc(8'h0c, 8'hf0);
      summarize();
   end
   // watchdog against a hang
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      failures++;
      summarize();
   end
endmodule : tb_thaoir_bank
